// ===== breaker_wear_monitor_tb.sv
// Self-checking bench for the breaker wear monitor: registers, clear, trips, alarms.
// Assumes bwm_feed_model on the trip side and the checker bound to bwm_top.
`timescale 1ns/1ps
`include "bwm_consts.svh"
module breaker_wear_monitor_tb;
  import bwm_pkg::*;
  localparam logic [15:0] A1 = 16'h0C1C;
  localparam logic [15:0] A2 = 16'h0258;
  logic           pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic           trip, alarm1, alarm2, fire;
  logic [7:0]     paddr;
  logic [31:0]    pwdata, prdata, time_stamp, seed, r, m, e;
  logic [127:0]   cvc;
  logic [135:0]   cvn;
  bwm_phase_cur_t phase_cur, cur_in;
  bwm_events_t    events;
  int             num_errors, samples_checked, cyc, on_cnt, i, k;

  bwm_top bwm_top_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .monitored_trip_output_select(trip), .phase_cur(phase_cur),
    .time_stamp(time_stamp), .alarm1(alarm1), .alarm2(alarm2), .events(events));
  bwm_feed_model bwm_feed_model_inst (.pclk(pclk), .presetn(presetn), .fire(fire),
    .cur_in(cur_in), .trip(trip), .phase_cur(phase_cur), .time_stamp(time_stamp));

  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (events.al2_on === 1'b1) on_cnt++;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Default curve, flat outside points 2 and 3
  function automatic real cnt_at(int c);
    real n;
    n = $ln(10000.0 / 80.0) / $ln(3100.0 / 125.0);
    if (c <= 125) return 10000.0;
    if (c >= 3100) return 80.0;
    return 10000.0 * $pow(125.0 / c, n);
  endfunction
  function automatic int dec(int al, int ph);
    if (ph < al) return 1;
    return int'(cnt_at(al) / cnt_at(ph));
  endfunction
  function automatic logic [31:0] near(longint s, longint x, longint t);
    return {31'h0, (s >= x - t) && (s <= x + t)};
  endfunction

  task check(input string nm, input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      $display("Error %s expected %h seen %h", nm, x, s);
      num_errors++;
    end
  endtask
  task give_verdict();
    if (num_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = 32'(pslverr);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task idle();
    repeat (8) @(posedge pclk);
    do apb(1'b0, `BWM_OFF_STATUS, 32'h0);
    while (r[`BWM_STAT_BUSY_BIT] !== 1'b0);
  endtask
  task trip_run(input logic [15:0] c1, input logic [15:0] c2, input logic [15:0] c3);
    logic [31:0] b[6];
    logic [15:0] c[3];
    int j, x, al;
    c = '{c1, c2, c3};
    for (j = 0; j < 6; j++) begin
      apb(1'b0, 8'(32'h60 + 4 * j), 32'h0);
      b[j] = r;
    end
    cur_in <= {c3, c2, c1};
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    idle();
    for (j = 0; j < 6; j++) begin
      al = (j < 3) ? A1 : A2;
      x = dec(al, c[j % 3]);
      apb(1'b0, 8'(32'h60 + 4 * j), 32'h0);
      check("ops_left", near(r, (b[j] > x) ? b[j] - x : 0, (c[j % 3] < al) ? 0 : 1), 32'h1);
    end
    for (j = 0; j < 3; j++) begin
      apb(1'b0, 8'(32'h78 + 4 * j), 32'h0);
      check("broken_current", r, {16'h0, c[j]});
    end
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, fire} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cur_in = '0;
    seed = 32'h36;
    cvc = `BWM_CV_CUR_RST;
    cvn = `BWM_CV_CNT_RST;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 6; i++) begin
      apb(1'b0, 8'(32'h60 + 4 * i), 32'h0);
      check("ops_reset", r, 32'(`BWM_OPS_RST));
    end
    for (i = 0; i < 8; i++) begin
      apb(1'b0, 8'(32'h20 + 4 * i), 32'h0);
      check("curve_cur", r, {16'h0, cvc[16*i +: 16]});
      apb(1'b0, 8'(32'h40 + 4 * i), 32'h0);
      check("curve_cnt", r, {15'h0, cvn[17*i +: 17]});
    end
    apb(1'b0, `BWM_OFF_AL1_LIM, 32'h0);
    check("lim_reset", r, 32'h1);
    apb(1'b0, `BWM_OFF_EVT_EN, 32'h0);
    check("evt_en_reset", r, 32'hF);
    apb(1'b0, `BWM_OFF_STATUS, 32'h0);
    check("status_reset", r, 32'h0);
    apb(1'b1, `BWM_OFF_AL1_CUR, 32'h0C1C);
    check("locked_err", e, 32'h1);
    apb(1'b1, `BWM_OFF_CMD, 32'h1);
    check("locked_clear", e, 32'h1);
    apb(1'b0, `BWM_OFF_AL1_CUR, 32'h0);
    check("locked_keep", r, 32'h0);
    apb(1'b1, `BWM_OFF_UNLOCK, `BWM_UNLOCK_KEY);
    apb(1'b1, 8'hFC, 32'h0);
    check("unmapped", e, 32'h1);
    apb(1'b1, `BWM_OFF_OPS_A1P1, 32'h0);
    check("ro_write", e, 32'h1);
    apb(1'b1, `BWM_OFF_AL1_LIM, 32'h0);
    apb(1'b0, `BWM_OFF_AL1_LIM, 32'h0);
    check("lim_low", r, 32'h1);
    apb(1'b1, `BWM_OFF_AL1_LIM, 32'h30D40);
    apb(1'b0, `BWM_OFF_AL1_LIM, 32'h0);
    check("lim_high", r, 32'h186A0);
    apb(1'b1, `BWM_OFF_AL1_CUR, 32'h4E20);
    apb(1'b0, `BWM_OFF_AL1_CUR, 32'h0);
    check("cur_clamp", r, 32'h2710);
    apb(1'b1, `BWM_OFF_AL1_CUR, {16'h0, A1});
    apb(1'b1, `BWM_OFF_AL2_CUR, {16'h0, A2});
    apb(1'b1, `BWM_OFF_AL1_LIM, 32'h1);
    apb(1'b1, `BWM_OFF_CMD, 32'h1);
    idle();
    for (i = 0; i < 6; i++) begin
      m = int'(cnt_at((i < 3) ? A1 : A2));
      apb(1'b0, 8'(32'h60 + 4 * i), 32'h0);
      check("cleared", near(r, m, m / 25 + 1), 32'h1);
    end
    trip_run(16'h04E2, 16'h0096, 16'h1388);
    for (i = 0; i < 5; i++) begin
      trip_run(16'(xs() % 32'hFA0), 16'(xs() % 32'hFA0), 16'(xs() % 32'hFA0));
    end
    m = 32'h1FFFF;
    for (i = 3; i < 6; i++) begin
      apb(1'b0, 8'(32'h60 + 4 * i), 32'h0);
      if (r < m) m = r;
    end
    apb(1'b1, `BWM_OFF_AL2_LIM, m);
    repeat (3) @(posedge pclk);
    check("alarm2_equal", {31'h0, alarm2}, 32'h0);
    apb(1'b1, `BWM_OFF_AL2_LIM, m + 32'h1);
    repeat (3) @(posedge pclk);
    check("alarm2_below", {31'h0, alarm2}, 32'h1);
    apb(1'b0, `BWM_OFF_STATUS, 32'h0);
    check("status_alarms", {30'h0, r[1:0]}, 32'h2);
    check("on_events", 32'(on_cnt), 32'h1);
    apb(1'b1, `BWM_OFF_EVT_EN, 32'hB);
    apb(1'b1, `BWM_OFF_AL2_LIM, 32'h1);
    apb(1'b1, `BWM_OFF_AL2_LIM, m + 32'h1);
    repeat (3) @(posedge pclk);
    check("on_masked", 32'(on_cnt), 32'h1);
    apb(1'b1, `BWM_OFF_UNLOCK, 32'h0);
    apb(1'b1, `BWM_OFF_AL2_LIM, 32'h1);
    check("relocked_err", e, 32'h1);
    check("relocked_alarm", {31'h0, alarm2}, 32'h1);
    give_verdict();
  end
endmodule // breaker_wear_monitor_tb

// ===== bwm_consts.svh
// Offsets, reset values and fixed figures of the breaker wear monitor.
// Assumes byte addresses on a 32-bit APB, one aligned word per register.
`ifndef BWM_CONSTS_SVH
`define BWM_CONSTS_SVH

`define BWM_ADDR_W      8
`define BWM_OFF_UNLOCK  8'h00
`define BWM_OFF_CMD     8'h04
`define BWM_OFF_EVT_EN  8'h08
`define BWM_OFF_AL1_CUR 8'h0C
`define BWM_OFF_AL1_LIM 8'h10
`define BWM_OFF_AL2_CUR 8'h14
`define BWM_OFF_AL2_LIM 8'h18
`define BWM_OFF_CV_CUR  3'h1
`define BWM_OFF_CV_CNT  3'h2
`define BWM_OFF_OPS_A1P1 8'h60
`define BWM_OFF_OPS_A1P2 8'h64
`define BWM_OFF_OPS_A1P3 8'h68
`define BWM_OFF_OPS_A2P1 8'h6C
`define BWM_OFF_OPS_A2P2 8'h70
`define BWM_OFF_OPS_A2P3 8'h74
`define BWM_OFF_BRK1    8'h78
`define BWM_OFF_BRK2    8'h7C
`define BWM_OFF_BRK3    8'h80
`define BWM_OFF_TSTAMP  8'h84
`define BWM_OFF_STATUS  8'h88

`define BWM_CMD_CLEAR_BIT 0
`define BWM_STAT_AL1_BIT  0
`define BWM_STAT_AL2_BIT  1
`define BWM_STAT_BUSY_BIT 2
`define BWM_STAT_UNL_BIT  3

// Currents in units of 10 A: 100.00 kA is 10000
`define BWM_CUR_MAX     16'h2710
`define BWM_FILLER_CNT  17'h00001
`define BWM_OPS_MAX     17'h186A0
`define BWM_OPS_MIN     17'h00001
`define BWM_OPS_RST     17'h186A0
`define BWM_LIM_RST     17'h00001
`define BWM_AL_CUR_RST  16'h0000
`define BWM_EVT_EN_RST  4'hF
// Default curve, point 8 in the top slot
`define BWM_CV_CUR_RST  {16'h2710, 16'h2710, 16'h2710, 16'h2710, 16'h2710, 16'h0C1C, 16'h007D, 16'h0000}
`define BWM_CV_CNT_RST  {17'h00001, 17'h00001, 17'h00001, 17'h00001, 17'h00001, 17'h00050, 17'h02710, 17'h02710}
// Arbitrary unlock key
`define BWM_UNLOCK_KEY  32'h5A5A_C3C3

`endif

// ===== bwm_div.sv
// Serial restoring divider, one quotient bit per clock.
// Assumes start only while idle; a zero divisor gives all ones.
`timescale 1ns/1ps
module bwm_div #(
  parameter int NW = 26,
  parameter int DW = 13
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          start,
  input  wire logic [NW-1:0] num,
  input  wire logic [DW-1:0] den,
  output logic               busy,
  output logic [NW-1:0]      quo
);
  localparam int CW = $clog2(NW + 1);
  logic [DW:0]   rem;
  logic [DW:0]   trial;
  logic [DW-1:0] dsr;
  logic [CW-1:0] cnt;

  assign trial = {rem[DW-1:0], quo[NW-1]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      quo  <= '0;
      rem  <= '0;
      dsr  <= '0;
      cnt  <= '0;
    end else if (start) begin
      busy <= 1'b1;
      quo  <= num;
      rem  <= '0;
      dsr  <= den;
      cnt  <= CW'(NW);
    end else if (busy) begin
      if (trial >= {1'b0, dsr}) begin
        rem <= trial - {1'b0, dsr};
        quo <= {quo[NW-2:0], 1'b1};
      end else begin
        rem <= trial;
        quo <= {quo[NW-2:0], 1'b0};
      end
      cnt <= cnt - 1'b1;
      if (cnt == CW'(1)) begin
        busy <= 1'b0;
      end
    end
  end
endmodule // bwm_div

// ===== bwm_feed_model.sv
// Far side: monitored trip pin, phase currents and a free-running time stamp.
// Assumes a one-cycle fire pulse with the currents to break.
`timescale 1ns/1ps
module bwm_feed_model (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    fire,
  input  wire bwm_pkg::bwm_phase_cur_t cur_in,
  output logic                         trip,
  output bwm_pkg::bwm_phase_cur_t      phase_cur,
  output logic [31:0]                  time_stamp
);
  import bwm_pkg::*;
  logic [3:0] hold;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold <= 4'h0;
      trip <= 1'b0;
      phase_cur <= '0;
      time_stamp <= 32'h0;
    end else begin
      time_stamp <= time_stamp + 32'h1;
      if (fire) begin
        phase_cur <= cur_in;
        trip <= 1'b1;
        hold <= 4'h8;
      end else if (hold != 4'h0) begin
        hold <= hold - 4'h1;
        // Longer than the two-flop sync
        if (hold == 4'h5) begin
          trip <= 1'b0;
        end
      end else begin
        // Moving currents expose a late latch
        phase_cur <= ~phase_cur;
      end
    end
  end
endmodule // bwm_feed_model

// ===== bwm_pkg.sv
// Types shared by the breaker wear monitor and its surroundings.
// Assumes bwm_consts.svh for all figures.
package bwm_pkg;
  typedef logic [15:0] bwm_cur_t;
  typedef logic [16:0] bwm_ops_t;
  typedef logic [12:0] bwm_log_t;

  typedef struct packed {
    bwm_cur_t ph3;
    bwm_cur_t ph2;
    bwm_cur_t ph1;
  } bwm_phase_cur_t;

  typedef struct packed {
    logic al2_off;
    logic al2_on;
    logic al1_off;
    logic al1_on;
  } bwm_events_t;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_SEEK  = 3'b001,
    S_DIVW  = 3'b011,
    S_STORE = 3'b010,
    S_APPLY = 3'b110
  } bwm_state_t;
endpackage

// ===== bwm_top.sv
// Breaker wear monitor: trip capture, log/log curve, operations-left counters.
// Assumes phase currents and time stamp on pclk; trip input is asynchronous.
//
// How it works
// RQ1 - Each pole's broken current is captured and worn separately.
// RQ2 - Broken currents latch only on the rising edge of the monitored trip.
// RQ3 - Wear curve is eight current and permitted-count pairs.
// RQ4 - Software fills unused points with oversized current and count one.
// RQ5 - Points with oversized current and count one are skipped.
// RQ6 - Between defined points 2 to 8, count follows a over current power n.
// RQ7 - Exponent n is log count ratio over log current ratio of the segment.
// RQ8 - Constant a is row-k count times row-k current to the n.
// RQ9 - Two alarms, each with a current from 0 to 100 kA and a limit.
// RQ10 - Operations-left limit is held between 1 and 100000.
// RQ11 - Trip decrements by count at alarm current over count at broken current.
// RQ12 - Broken current below the alarm current decrements by exactly one.
// RQ13 - Decrement rounds to whole operations; counters stop at zero.
// RQ14 - Three readable counters per alarm, six in all.
// RQ15 - Each alarm watches only the smallest of its three counters.
// RQ16 - Alarm output rises when that minimum falls below the limit.
// RQ17 - Alarm on and off events, each with its own enable.
// RQ18 - Clear reloads every counter with the count at its alarm current.
// RQ19 - Latest trip keeps a time stamp and three broken currents.
// RQ20 - Settings and clear are refused until the unlock key is written.
`timescale 1ns/1ps
`include "bwm_consts.svh"
module bwm_top (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic [`BWM_ADDR_W-1:0]   paddr,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [31:0]              pwdata,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     monitored_trip_output_select,
  input  wire bwm_pkg::bwm_phase_cur_t  phase_cur,
  input  wire logic [31:0]              time_stamp,
  output logic                          alarm1,
  output logic                          alarm2,
  output bwm_pkg::bwm_events_t          events
);
  import bwm_pkg::*;
  localparam logic [127:0] CV_CUR_RST = `BWM_CV_CUR_RST;
  localparam logic [135:0] CV_CNT_RST = `BWM_CV_CNT_RST;

  bwm_cur_t   cv_cur [8];
  bwm_ops_t   cv_cnt [8];
  bwm_cur_t   al_cur [2];
  bwm_ops_t   al_lim [2];
  logic [3:0] evt_en;
  logic       unlocked;
  bwm_ops_t   ops [2][3];
  bwm_cur_t   brk [3];
  logic [31:0] tstamp;
  logic       trip_s1, trip_s2, trip_d;
  logic       trip_pend, clear_pend;
  bwm_state_t state;
  logic       job_clear;
  bwm_cur_t   job_cur [5];
  bwm_log_t   logc [5];
  logic [2:0] ei;
  bwm_log_t   base_log;
  logic       use_div, div_start, div_busy;
  logic [25:0] div_quo;
  logic       trip_edge, acc, wr, rd_err;
  logic [31:0] rd_data;

  function automatic bwm_log_t log2c(input logic [16:0] x);
    logic [4:0]  p;
    logic [16:0] nrm;
    p = 5'd0;
    for (int i = 0; i < 17; i++) begin
      if (x[i]) begin
        p = 5'(i);
      end
    end
    nrm = x << (5'd16 - p);
    return {p, nrm[15:8]};
  endfunction

  // Rounded 2^v; mantissa is linear, so a few percent of error is accepted
  function automatic bwm_ops_t exp2r(input bwm_log_t v);
    logic [25:0] val;
    if (v[12:8] > 5'd16) begin
      return 17'h1FFFF;
    end
    val = 26'({1'b1, v[7:0]}) << v[12:8];
    val = val + 26'h0000080;
    return val[24:8];
  endfunction

  function automatic logic point_valid(input bwm_cur_t c, input bwm_ops_t n);
    return !(c >= `BWM_CUR_MAX && n == `BWM_FILLER_CNT); // [RQ5]
  endfunction

  function automatic bwm_ops_t clamp_lim(input logic [31:0] d);
    if (d < 32'(`BWM_OPS_MIN)) begin
      return `BWM_OPS_MIN;
    end
    if (d > 32'(`BWM_OPS_MAX)) begin
      return `BWM_OPS_MAX;
    end
    return d[16:0];
  endfunction

  function automatic bwm_cur_t clamp_cur(input logic [31:0] d);
    return (d > 32'(`BWM_CUR_MAX)) ? `BWM_CUR_MAX : d[15:0];
  endfunction

  // Trip pin synchroniser and edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_s1 <= 1'b0;
      trip_s2 <= 1'b0;
      trip_d  <= 1'b0;
    end else begin
      trip_s1 <= monitored_trip_output_select;
      trip_s2 <= trip_s1;
      trip_d  <= trip_s2;
    end
  end
  assign trip_edge = trip_s2 & ~trip_d;

  // Latest trip record
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk    <= '{default: '0};
      tstamp <= '0;
    end else if (trip_edge) begin
      brk[0] <= phase_cur.ph1; // [RQ1] [RQ2]
      brk[1] <= phase_cur.ph2;
      brk[2] <= phase_cur.ph3;
      tstamp <= time_stamp; // [RQ19]
    end
  end

  // APB: one wait state; read data is registered as pready rises, writes land one edge later while pready is high
  assign acc = psel & penable & pready;
  assign wr  = acc & pwrite & ~pslverr;

  always_comb begin
    rd_data = '0;
    rd_err  = 1'b0;
    if (paddr[7:5] == `BWM_OFF_CV_CUR) begin
      rd_data = 32'(cv_cur[paddr[4:2]]);
    end else if (paddr[7:5] == `BWM_OFF_CV_CNT) begin
      rd_data = 32'(cv_cnt[paddr[4:2]]);
    end else begin
      case (paddr)
        `BWM_OFF_UNLOCK:   rd_data = '0;
        `BWM_OFF_CMD:      rd_data = '0;
        `BWM_OFF_EVT_EN:   rd_data = 32'(evt_en);
        `BWM_OFF_AL1_CUR:  rd_data = 32'(al_cur[0]);
        `BWM_OFF_AL1_LIM:  rd_data = 32'(al_lim[0]);
        `BWM_OFF_AL2_CUR:  rd_data = 32'(al_cur[1]);
        `BWM_OFF_AL2_LIM:  rd_data = 32'(al_lim[1]);
        `BWM_OFF_OPS_A1P1: rd_data = 32'(ops[0][0]); // [RQ14]
        `BWM_OFF_OPS_A1P2: rd_data = 32'(ops[0][1]);
        `BWM_OFF_OPS_A1P3: rd_data = 32'(ops[0][2]);
        `BWM_OFF_OPS_A2P1: rd_data = 32'(ops[1][0]);
        `BWM_OFF_OPS_A2P2: rd_data = 32'(ops[1][1]);
        `BWM_OFF_OPS_A2P3: rd_data = 32'(ops[1][2]);
        `BWM_OFF_BRK1:     rd_data = 32'(brk[0]);
        `BWM_OFF_BRK2:     rd_data = 32'(brk[1]);
        `BWM_OFF_BRK3:     rd_data = 32'(brk[2]);
        `BWM_OFF_TSTAMP:   rd_data = tstamp;
        `BWM_OFF_STATUS: begin
          rd_data[`BWM_STAT_AL1_BIT]  = alarm1;
          rd_data[`BWM_STAT_AL2_BIT]  = alarm2;
          rd_data[`BWM_STAT_BUSY_BIT] = (state != S_IDLE);
          rd_data[`BWM_STAT_UNL_BIT]  = unlocked;
        end
        default:           rd_err = 1'b1;
      endcase
    end
    // Read-only words refuse writes; settings refuse writes while locked
    if (pwrite && paddr != `BWM_OFF_UNLOCK) begin
      if (paddr >= `BWM_OFF_OPS_A1P1 || !unlocked) begin
        rd_err = 1'b1; // [RQ20]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & rd_err;
      if (psel && penable && !pready && !pwrite) begin
        prdata <= rd_data;
      end
    end
  end

  // Settings, all behind the unlock key
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlocked <= 1'b0;
      evt_en   <= `BWM_EVT_EN_RST;
      al_cur   <= '{default: `BWM_AL_CUR_RST};
      al_lim   <= '{default: `BWM_LIM_RST};
      // Point 1 sits in the low slice of each default word
      for (int i = 0; i < 8; i++) begin
        cv_cur[i] <= CV_CUR_RST[16*i +: 16];
        cv_cnt[i] <= CV_CNT_RST[17*i +: 17];
      end
    end else if (acc && pwrite && paddr == `BWM_OFF_UNLOCK) begin
      unlocked <= (pwdata == `BWM_UNLOCK_KEY); // [RQ20]
    end else if (wr) begin
      if (paddr[7:5] == `BWM_OFF_CV_CUR) begin
        cv_cur[paddr[4:2]] <= pwdata[15:0]; // [RQ3]
      end else if (paddr[7:5] == `BWM_OFF_CV_CNT) begin
        cv_cnt[paddr[4:2]] <= pwdata[16:0];
      end else begin
        case (paddr)
          `BWM_OFF_EVT_EN:  evt_en    <= pwdata[3:0];
          `BWM_OFF_AL1_CUR: al_cur[0] <= clamp_cur(pwdata); // [RQ9]
          `BWM_OFF_AL1_LIM: al_lim[0] <= clamp_lim(pwdata); // [RQ10]
          `BWM_OFF_AL2_CUR: al_cur[1] <= clamp_cur(pwdata);
          `BWM_OFF_AL2_LIM: al_lim[1] <= clamp_lim(pwdata);
          default:          ;
        endcase
      end
    end
  end

  // Pending work; a new request in the start cycle wins over the take
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_pend  <= 1'b0;
      clear_pend <= 1'b0;
    end else begin
      if (state == S_IDLE) begin
        if (clear_pend) begin
          clear_pend <= 1'b0;
        end else if (trip_pend) begin
          trip_pend <= 1'b0;
        end
      end
      if (trip_edge) begin
        trip_pend <= 1'b1;
      end
      if (wr && paddr == `BWM_OFF_CMD && pwdata[`BWM_CMD_CLEAR_BIT]) begin
        clear_pend <= 1'b1; // [RQ18] [RQ20]
      end
    end
  end

  // Segment search over points 2..8 for the current under evaluation
  bwm_cur_t    x_cur;
  logic [2:0]  lo_i, hi_i;
  logic        found, hi_ok;
  bwm_log_t    lc_lo, lc_hi, li_x, li_lo, li_hi;
  bwm_log_t    dlc, dli, den;

  always_comb begin
    x_cur = job_cur[ei];
    lo_i  = 3'd1;
    hi_i  = 3'd1;
    found = 1'b0;
    hi_ok = 1'b0;
    for (int k = 1; k < 8; k++) begin
      if (point_valid(cv_cur[k], cv_cnt[k])) begin
        if (cv_cur[k] <= x_cur) begin
          lo_i  = 3'(k);
          found = 1'b1;
          hi_ok = 1'b0;
        end else if (found && !hi_ok) begin
          hi_i  = 3'(k);
          hi_ok = 1'b1;
        end
      end
    end
    lc_lo = log2c(cv_cnt[lo_i]);
    lc_hi = log2c(cv_cnt[hi_i]);
    li_x  = log2c({1'b0, x_cur});
    li_lo = log2c({1'b0, cv_cur[lo_i]});
    li_hi = log2c({1'b0, cv_cur[hi_i]});
    // n = dlc/den and log a = log Ck + n log Ik, so log C = log Ck - n dli
    dlc = (lc_lo > lc_hi) ? lc_lo - lc_hi : '0; // [RQ7]
    dli = (li_x > li_lo) ? li_x - li_lo : '0; // [RQ8]
    den = (li_hi > li_lo) ? li_hi - li_lo : '0;
  end

  bwm_div #(
    .NW(26),
    .DW(13)
  ) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (div_start),
    .num     (dlc * dli),
    .den     (den),
    .busy    (div_busy),
    .quo     (div_quo)
  );

  // Evaluation engine: two alarm currents, then three broken currents
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= S_IDLE;
      job_clear <= 1'b0;
      job_cur   <= '{default: '0};
      logc      <= '{default: '0};
      ei        <= '0;
      base_log  <= '0;
      use_div   <= 1'b0;
      div_start <= 1'b0;
    end else begin
      div_start <= 1'b0;
      case (state)
        S_IDLE: begin
          if (clear_pend || trip_pend) begin
            job_clear <= clear_pend;
            job_cur   <= '{al_cur[0], al_cur[1], brk[0], brk[1], brk[2]}; // [RQ1]
            ei        <= '0;
            state     <= S_SEEK;
          end
        end
        S_SEEK: begin
          base_log  <= lc_lo;
          use_div   <= found && hi_ok && den != '0; // [RQ6]
          div_start <= found && hi_ok && den != '0;
          state     <= S_DIVW;
        end
        S_DIVW: begin
          if (!div_start && !div_busy) begin
            state <= S_STORE;
          end
        end
        S_STORE: begin
          if (!use_div) begin
            logc[ei] <= base_log;
          end else if (div_quo >= 26'(base_log)) begin
            logc[ei] <= '0;
          end else begin
            logc[ei] <= base_log - div_quo[12:0]; // [RQ6]
          end
          if (ei == 3'd4) begin
            state <= S_APPLY;
          end else begin
            ei    <= ei + 3'd1;
            state <= S_SEEK;
          end
        end
        S_APPLY: state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
    end
  end

  // Operations-left counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ops <= '{default: '{default: `BWM_OPS_RST}};
    end else if (state == S_APPLY) begin
      for (int a = 0; a < 2; a++) begin
        for (int p = 0; p < 3; p++) begin
          if (job_clear) begin
            ops[a][p] <= exp2r(logc[a]); // [RQ18]
          end else begin
            ops[a][p] <= sat_dec(ops[a][p], a, p);
          end
        end
      end
    end
  end

  function automatic bwm_ops_t sat_dec(input bwm_ops_t cur, input int a, input int p);
    bwm_ops_t d;
    d = 17'h00001; // [RQ12]
    if (job_cur[2 + p] >= job_cur[a] && logc[a] > logc[2 + p]) begin
      d = exp2r(logc[a] - logc[2 + p]); // [RQ11] [RQ13]
      if (d == '0) begin
        d = 17'h00001;
      end
    end
    return (cur > d) ? cur - d : '0; // [RQ13]
  endfunction

  // Alarms on the smallest counter and their events
  logic [1:0] next_alarm;
  always_comb begin
    bwm_ops_t m;
    m = '0;
    next_alarm = '0;
    for (int a = 0; a < 2; a++) begin
      m = ops[a][0];
      for (int p = 1; p < 3; p++) begin
        if (ops[a][p] < m) begin
          m = ops[a][p]; // [RQ15]
        end
      end
      next_alarm[a] = (m < al_lim[a]); // [RQ16]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm1 <= 1'b0;
      alarm2 <= 1'b0;
      events <= '0;
    end else begin
      alarm1 <= next_alarm[0];
      alarm2 <= next_alarm[1];
      events.al1_on  <= evt_en[0] & next_alarm[0] & ~alarm1; // [RQ17]
      events.al1_off <= evt_en[1] & ~next_alarm[0] & alarm1;
      events.al2_on  <= evt_en[2] & next_alarm[1] & ~alarm2;
      events.al2_off <= evt_en[3] & ~next_alarm[1] & alarm2;
    end
  end
endmodule // bwm_top

// ===== bwm_top_properties.sv
// Port checker for the breaker wear monitor: APB answers, refusals, alarm events.
// Assumes it is bound to bwm_top and sees only that module's ports.
`timescale 1ns/1ps
`include "bwm_consts.svh"
module bwm_top_properties (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic [`BWM_ADDR_W-1:0]  paddr,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [31:0]             pwdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic                    alarm1,
  input wire logic                    alarm2,
  input wire bwm_pkg::bwm_events_t    events
);
  import bwm_pkg::*;
  logic       unl;
  logic [3:0] en;
  logic       done;
  assign done = psel & penable & pready;
  // Lock and enable shadows from completed writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unl <= 1'b0;
    end else if (done && pwrite && paddr == `BWM_OFF_UNLOCK) begin
      unl <= (pwdata == `BWM_UNLOCK_KEY);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en <= `BWM_EVT_EN_RST;
    end else if (done && pwrite && unl && paddr == `BWM_OFF_EVT_EN) begin
      en <= pwdata[3:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_ONE_WAIT: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready late");
  AST_READY_PULSE: assert property (pready |-> psel && penable ##1 !pready)
    else $error("stray pready");
  AST_BAD_ADDR: assert property (done && (paddr > `BWM_OFF_STATUS || paddr == 8'h1C) |-> pslverr)
    else $error("unmapped not refused");
  AST_RO_WRITE: assert property (done && pwrite && paddr >= `BWM_OFF_OPS_A1P1 |-> pslverr)
    else $error("read-only write taken");
  AST_READ_OK: assert property (done && !pwrite && paddr <= `BWM_OFF_STATUS && paddr != 8'h1C |-> !pslverr)
    else $error("mapped read refused");
  AST_LOCKED: assert property (done && pwrite && !unl && (paddr inside {[8'h04:8'h5C]}) |-> pslverr)
    else $error("locked write taken");
  AST_AL1_ON: assert property ($rose(alarm1) |-> events.al1_on == en[0])
    else $error("alarm1 on event wrong");
  AST_AL2_OFF: assert property ($fell(alarm2) |-> events.al2_off == en[3])
    else $error("alarm2 off event wrong");
  AST_EVT_CAUSE: assert property (events.al2_on |-> $rose(alarm2) && en[2])
    else $error("stray alarm2 on event");
  AST_EVT_PULSE: assert property (events != 4'h0 |=> (events & $past(events)) == 4'h0)
    else $error("event too long");
  cover property (done && pslverr);
  cover property ($rose(alarm2));
  cover property (events.al2_off);
endmodule // bwm_top_properties

bind bwm_top bwm_top_properties bwm_top_properties_inst (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .alarm1(alarm1), .alarm2(alarm2), .events(events)
);
